// ---- pll_ctrl_pkg.sv ----
// Purpose: Shared constants and types for the clock synthesizer control block
// Assumes: APB slave with 32-bit data, one word per register
// Notes: Divider defaults match the parallel pin defaults
package pll_ctrl_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CFG_STAGE = 8'h00;
    localparam logic [7:0] OFS_COMMAND = 8'h04;
    localparam logic [7:0] OFS_CFG_ACTIVE = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // Field positions
    localparam int CMD_LOAD_BIT = 0;
    localparam int STATUS_LOCK_BIT = 0;
    localparam int STATUS_SERIAL_BIT = 1;
    localparam int STATUS_REF_VALID_BIT = 2;
    localparam int CFG_WIDTH = 15;

    // Divider configuration as carried on pins and in registers
    typedef struct packed {
        logic [9:0] feedback_div;
        logic [2:0] output_a_div;
        logic output_b_postdivider;
        logic predivider;
    } divider_cfg_t;

    // Reset and open-pin defaults
    localparam logic [9:0] DEF_FEEDBACK_DIV = 10'h1F4;
    localparam logic [2:0] DEF_OUTPUT_A_DIV = 3'h2;
    localparam logic DEF_POSTDIV = 1'b0;
    localparam logic DEF_PREDIV = 1'b1;
    localparam divider_cfg_t CFG_DEFAULT = '{
        feedback_div: DEF_FEEDBACK_DIV,
        output_a_div: DEF_OUTPUT_A_DIV,
        output_b_postdivider: DEF_POSTDIV,
        predivider: DEF_PREDIV
    };

    // Postdivider encoding: 0 gives divide by 1, 1 gives divide by 2
    localparam logic POSTDIV_BY_2 = 1'b1;

    // Lock filter length in synthesized clock (clk) cycles
    localparam int LOCK_FILTER_CYCLES = 16;

    // Indicated lock state
    typedef enum logic [0:0] {
        LOCK_OFF = 1'b0,
        LOCK_ON = 1'b1
    } lock_state_t;

    // Phase of the synthesized clock, two bits of a free-running count
    localparam logic [1:0] PHASE_ONE = 2'h1;
    localparam logic [1:0] PHASE_TWO = 2'h2;
    localparam logic [1:0] PHASE_STEP = 2'h1;

endpackage

// ---- input_sync.sv ----
// Purpose: Two-stage synchronizer for a vector of pin inputs
// Assumes: Each bit is a level that changes slowly against clk
// Notes: Bits are synchronized independently
`timescale 1ns/1ps
module input_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    generate
        if (WIDTH < 1) begin : g_check
            $error("input_sync WIDTH must be at least 1");
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule // input_sync

// ---- output_gate.sv ----
// Purpose: Glitch-free stop gate for one differential clock output
// Assumes: phase_high is the clock level for the next output cycle
// Notes: Gate changes only while the clock phase is low
`timescale 1ns/1ps
module output_gate (
    input wire logic clk,
    input wire logic out_rst_n,
    input wire logic phase_high,
    input wire logic run,
    output logic clock_out,
    output logic clock_out_n
);
    logic gate;
    logic next_gate;
    logic next_out;

    always_comb begin
        next_gate = phase_high ? gate : run;
        next_out = phase_high & gate;
    end

    always_ff @(posedge clk or negedge out_rst_n) begin
        if (!out_rst_n) begin
            gate <= 1'b0;
            clock_out <= 1'b0;
            clock_out_n <= 1'b1;
        end else begin
            gate <= next_gate;
            clock_out <= next_out;
            clock_out_n <= ~next_out;
        end
    end
endmodule // output_gate

// ---- pll_lock_and_output_stop.sv ----
// Purpose: Startup, lock indication and output stop control of a clock synthesizer
// Assumes: clk stands for the synthesized clock; lock_raw comes from the analog detector
// Notes: Registers reached over APB; pins pass two flip-flops before use, except master_reset_n, which also resets the outputs at once
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
module pll_lock_and_output_stop #(
    parameter int LOCK_FILTER_CYCLES = pll_ctrl_pkg::LOCK_FILTER_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic master_reset_n,
    input wire logic parallel_load_select_n,
    input wire logic [1:0] output_run_enable_n,
    input wire logic bypass_select_n,
    input wire logic production_test_in,
    input wire logic lock_raw,
    input wire logic reference_valid,
    input wire pll_ctrl_pkg::divider_cfg_t divider_pins,
    output pll_ctrl_pkg::divider_cfg_t divider_config,
    output logic lock_out,
    output logic clock_out_a,
    output logic clock_out_a_n,
    output logic clock_out_b,
    output logic clock_out_b_n
);
    localparam int SYNC_W = pll_ctrl_pkg::CFG_WIDTH + 8;
    localparam int CW = (LOCK_FILTER_CYCLES > 2) ? $clog2(LOCK_FILTER_CYCLES) : 1;
    localparam logic [CW-1:0] CNT_LAST = CW'(LOCK_FILTER_CYCLES - 1);
    localparam logic [CW-1:0] CNT_STEP = CW'(1);

    generate
        if (LOCK_FILTER_CYCLES < 2) begin : g_check
            $error("LOCK_FILTER_CYCLES must be at least 2");
        end
        if (pll_ctrl_pkg::CFG_WIDTH != $bits(pll_ctrl_pkg::divider_cfg_t)) begin : g_width
            $error("CFG_WIDTH must match the divider configuration width");
        end
    endgenerate

    // Synchronized pin levels
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    pll_ctrl_pkg::divider_cfg_t pins_s;
    logic mr_s;
    logic serial_s;
    logic [1:0] run_s;
    logic bypass_n_s;
    logic test_s;
    logic raw_s;
    logic ref_s;

    assign sync_in = {divider_pins, master_reset_n, parallel_load_select_n, output_run_enable_n,
                      bypass_select_n, production_test_in, lock_raw, reference_valid};

    input_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(sync_in),
        .q(sync_out)
    );

    assign pins_s = pll_ctrl_pkg::divider_cfg_t'(sync_out[SYNC_W-1:8]);
    assign mr_s = sync_out[7];
    assign serial_s = sync_out[6];
    assign run_s = sync_out[5:4];
    assign bypass_n_s = sync_out[3];
    assign test_s = sync_out[2];
    assign raw_s = sync_out[1];
    assign ref_s = sync_out[0];

    // Register decode
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
        addr_hit = (addr == ofs);
    endfunction

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = addr_hit(addr, pll_ctrl_pkg::OFS_CFG_STAGE) || addr_hit(addr, pll_ctrl_pkg::OFS_COMMAND) ||
                    addr_hit(addr, pll_ctrl_pkg::OFS_CFG_ACTIVE) || addr_hit(addr, pll_ctrl_pkg::OFS_STATUS);
    endfunction

    // Bus and configuration state
    logic mr_prev;
    pll_ctrl_pkg::divider_cfg_t stage;
    logic next_mr_prev;
    pll_ctrl_pkg::divider_cfg_t next_stage;
    pll_ctrl_pkg::divider_cfg_t next_active;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic wr_take;
    logic mr_rise;
    logic cfg_change;
    logic wr_stage;
    logic wr_load;

    // Lock state
    pll_ctrl_pkg::lock_state_t lock_state;
    pll_ctrl_pkg::lock_state_t next_lock_state;
    logic [CW-1:0] filt_cnt;
    logic [CW-1:0] next_filt_cnt;
    logic next_lock_out;

    // Output clock phase
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic a_high;
    logic b_high;
    logic [1:0] phase_high;
    logic [1:0] out_true;
    logic [1:0] out_comp;
    logic out_rst_n;
    logic mr_async_n;
    logic [1:0] out_rst_q;
    logic [1:0] next_out_rst_q;

    always_comb begin
        next_mr_prev = mr_s;
        mr_rise = mr_s & ~mr_prev;
        next_pready = psel & penable & ~pready;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        wr_take = psel & penable & pready & pwrite & mr_s & ~pslverr;
        wr_stage = wr_take & addr_hit(paddr, pll_ctrl_pkg::OFS_CFG_STAGE);
        wr_load = wr_take & addr_hit(paddr, pll_ctrl_pkg::OFS_COMMAND) & pwdata[pll_ctrl_pkg::CMD_LOAD_BIT];
        next_stage = stage;
        next_active = divider_config;
        if (psel & penable & ~pready) begin
            if (!mr_s || !is_mapped(paddr)) begin
                next_pslverr = 1'b1;
            end else if (!pwrite) begin
                unique case (paddr)
                    pll_ctrl_pkg::OFS_CFG_STAGE: next_prdata[pll_ctrl_pkg::CFG_WIDTH-1:0] = stage;
                    pll_ctrl_pkg::OFS_CFG_ACTIVE: next_prdata[pll_ctrl_pkg::CFG_WIDTH-1:0] = divider_config;
                    pll_ctrl_pkg::OFS_STATUS: begin
                        next_prdata[pll_ctrl_pkg::STATUS_LOCK_BIT] = lock_state;
                        next_prdata[pll_ctrl_pkg::STATUS_SERIAL_BIT] = serial_s;
                        next_prdata[pll_ctrl_pkg::STATUS_REF_VALID_BIT] = ref_s;
                    end
                    default: next_prdata = 32'h0000_0000;
                endcase
            end
        end
        if (wr_stage) begin
            next_stage = pll_ctrl_pkg::divider_cfg_t'(pwdata[pll_ctrl_pkg::CFG_WIDTH-1:0]);
        end
        // Status writes fall through with no effect
        if (!mr_s) begin
            next_stage = pll_ctrl_pkg::CFG_DEFAULT;
            next_active = pll_ctrl_pkg::CFG_DEFAULT;
        end else if (mr_rise) begin
            next_active = pins_s;
            next_stage = pins_s;
        end else if (!serial_s) begin
            next_active = pins_s;
            next_stage = pins_s;
        end else if (wr_load) begin
            next_active = stage;
        end
        cfg_change = (next_active.feedback_div != divider_config.feedback_div) ||
                     (next_active.predivider != divider_config.predivider);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mr_prev <= 1'b0;
            stage <= pll_ctrl_pkg::CFG_DEFAULT;
            divider_config <= pll_ctrl_pkg::CFG_DEFAULT;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            mr_prev <= next_mr_prev;
            stage <= next_stage;
            divider_config <= next_active;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // Lock filter
    always_comb begin
        next_lock_state = lock_state;
        next_filt_cnt = filt_cnt;
        if (!mr_s || cfg_change) begin
            next_lock_state = pll_ctrl_pkg::LOCK_OFF;
            next_filt_cnt = '0;
        end else if (ref_s) begin
            if (raw_s != lock_state) begin
                if (filt_cnt == CNT_LAST) begin
                    next_lock_state = pll_ctrl_pkg::lock_state_t'(raw_s);
                    next_filt_cnt = '0;
                end else begin
                    next_filt_cnt = filt_cnt + CNT_STEP;
                end
            end else begin
                next_filt_cnt = '0;
            end
        end
        next_lock_out = bypass_n_s ? next_lock_state : test_s;
    end

    always_ff @(posedge clk or negedge out_rst_n) begin
        if (!out_rst_n) begin
            lock_state <= pll_ctrl_pkg::LOCK_OFF;
            filt_cnt <= '0;
            lock_out <= 1'b0;
        end else begin
            lock_state <= next_lock_state;
            filt_cnt <= next_filt_cnt;
            lock_out <= next_lock_out;
        end
    end

    // Output reset: asserts at once, releases after two clk edges
    assign mr_async_n = rst_n & master_reset_n;

    always_comb begin
        next_out_rst_q = {out_rst_q[0], 1'b1};
    end

    always_ff @(posedge clk or negedge mr_async_n) begin
        if (!mr_async_n) begin
            out_rst_q <= 2'h0;
        end else begin
            out_rst_q <= next_out_rst_q;
        end
    end

    assign out_rst_n = out_rst_q[1];

    // Free-running phase shared by both outputs

    always_comb begin
        next_phase = phase + pll_ctrl_pkg::PHASE_STEP;
        a_high = phase[0];
        if (divider_config.output_b_postdivider == pll_ctrl_pkg::POSTDIV_BY_2) begin
            b_high = (phase == pll_ctrl_pkg::PHASE_ONE) || (phase == pll_ctrl_pkg::PHASE_TWO);
        end else begin
            b_high = phase[0];
        end
        phase_high = {b_high, a_high};
    end

    always_ff @(posedge clk or negedge out_rst_n) begin
        if (!out_rst_n) begin
            phase <= 2'h0;
        end else begin
            phase <= next_phase;
        end
    end

    // Separate gate per output
    generate
        for (genvar i = 0; i < 2; i++) begin : g_out
            output_gate u_gate (
                .clk(clk),
                .out_rst_n(out_rst_n),
                .phase_high(phase_high[i]),
                .run(run_s[i]),
                .clock_out(out_true[i]),
                .clock_out_n(out_comp[i])
            );
        end
    endgenerate

    assign clock_out_a = out_true[0];
    assign clock_out_a_n = out_comp[0];
    assign clock_out_b = out_true[1];
    assign clock_out_b_n = out_comp[1];
endmodule // pll_lock_and_output_stop

// ---- pll_lock_and_output_stop_sva.sv ----
// Purpose: Checker for lock indication and output stop gating
// Assumes: Sees top ports only; pins settle within six cycles
// Notes: Attached by bind below
`timescale 1ns/1ps
module pll_lock_and_output_stop_sva #(
    parameter int LOCK_FILTER_CYCLES = pll_ctrl_pkg::LOCK_FILTER_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic master_reset_n,
    input wire logic [1:0] output_run_enable_n,
    input wire logic bypass_select_n,
    input wire logic production_test_in,
    input wire logic lock_raw,
    input wire pll_ctrl_pkg::divider_cfg_t divider_config,
    input wire logic lock_out,
    input wire logic clock_out_a,
    input wire logic clock_out_a_n,
    input wire logic clock_out_b,
    input wire logic clock_out_b_n
);
    int raw_run;
    int next_raw_run;
    always_comb next_raw_run = lock_raw ? raw_run + 1 : 0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) raw_run <= 0;
        else raw_run <= next_raw_run;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || !master_reset_n);
    AST_STOP_A: assert property (
        (!output_run_enable_n[0]) [*6] |-> !clock_out_a && clock_out_a_n) else $error("output a not parked");
    AST_FULL_PULSE: assert property (
        $rose(clock_out_a) |=> !clock_out_a) else $error("output a pulse width wrong");
    AST_B_ALIGN: assert property (
        output_run_enable_n[0] [*6] ##0 $rose(clock_out_b) |-> $rose(clock_out_a)) else $error("b edge off a edge");
    AST_B_HALF: assert property (
        $rose(clock_out_b) && divider_config.output_b_postdivider |=> clock_out_b ##1 !clock_out_b)
        else $error("b half rate pulse wrong");
    AST_LOCK_DROP: assert property (
        bypass_select_n && $past(bypass_select_n, 4) && $changed(divider_config.feedback_div) |-> !lock_out)
        else $error("lock kept over divider change");
    AST_LOCK_FILTER: assert property (
        bypass_select_n && $past(bypass_select_n, 4) && $rose(lock_out) |-> raw_run >= LOCK_FILTER_CYCLES)
        else $error("lock rose before filter");
    AST_BYPASS: assert property (
        (!bypass_select_n && $stable(production_test_in)) [*5] |-> lock_out == production_test_in)
        else $error("test output wrong");
    AST_MR_ASYNC: assert property (disable iff (!rst_n)
        !master_reset_n |-> !clock_out_a && !clock_out_b && clock_out_a_n && clock_out_b_n)
        else $error("outputs not forced");
    AST_COMP_PAIR: assert property (
        clock_out_a_n == !clock_out_a && clock_out_b_n == !clock_out_b) else $error("complement side wrong");
    AST_REFUSE: assert property (disable iff (!rst_n)
        (!master_reset_n) [*5] ##0 pready |-> pslverr) else $error("access not refused");
    cover property ($rose(lock_out));
    cover property ($rose(clock_out_b) && divider_config.output_b_postdivider);
    cover property (disable iff (!rst_n) pready && pslverr);
endmodule // pll_lock_and_output_stop_sva

bind pll_lock_and_output_stop pll_lock_and_output_stop_sva #(.LOCK_FILTER_CYCLES(LOCK_FILTER_CYCLES)) chk_i (
    .clk(clk), .rst_n(rst_n), .pready(pready), .pslverr(pslverr), .master_reset_n(master_reset_n),
    .output_run_enable_n(output_run_enable_n), .bypass_select_n(bypass_select_n),
    .production_test_in(production_test_in), .lock_raw(lock_raw), .divider_config(divider_config),
    .lock_out(lock_out), .clock_out_a(clock_out_a), .clock_out_a_n(clock_out_a_n), .clock_out_b(clock_out_b),
    .clock_out_b_n(clock_out_b_n));

// ---- pll_far_side_model.sv ----
// Purpose: Loop detector model feeding the raw lock level
// Assumes: Relock after feedback or predivider change
// Notes: Slow mode stretches the settle time
`timescale 1ns/1ps
module pll_far_side_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire pll_ctrl_pkg::divider_cfg_t cfg,
    output logic lock_raw
);
    logic [10:0] last;
    int cnt;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            lock_raw <= 1'b0;
            last <= 11'h000;
        end else begin
            last <= {cfg.feedback_div, cfg.predivider};
            if ({cfg.feedback_div, cfg.predivider} !== last) begin
                cnt <= 0;
                lock_raw <= 1'b0;
            end else if (cnt < (slow ? 40 : 10)) cnt <= cnt + 1;
            else lock_raw <= 1'b1;
        end
    end
endmodule // pll_far_side_model

// ---- pll_lock_and_output_stop_tb.sv ----
// Purpose: Self-checking bench for lock and output stop control
// Assumes: Filter shortened to four cycles
// Notes: Register access over APB tasks
`timescale 1ns/1ps
module pll_lock_and_output_stop_tb;
    localparam logic [7:0] A_STAGE = pll_ctrl_pkg::OFS_CFG_STAGE;
    localparam logic [7:0] A_ACT = pll_ctrl_pkg::OFS_CFG_ACTIVE;
    localparam logic [7:0] A_STAT = pll_ctrl_pkg::OFS_STATUS;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, master_reset_n, parallel_load_select_n;
    logic bypass_select_n, production_test_in, lock_raw, reference_valid, slow, err;
    logic lock_out, clock_out_a, clock_out_a_n, clock_out_b, clock_out_b_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] output_run_enable_n;
    pll_ctrl_pkg::divider_cfg_t divider_pins, divider_config;
    int errors, num_checks, ra, rb;
    pll_lock_and_output_stop #(.LOCK_FILTER_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .master_reset_n(master_reset_n), .parallel_load_select_n(parallel_load_select_n),
        .output_run_enable_n(output_run_enable_n), .bypass_select_n(bypass_select_n),
        .production_test_in(production_test_in), .lock_raw(lock_raw), .reference_valid(reference_valid),
        .divider_pins(divider_pins), .divider_config(divider_config), .lock_out(lock_out),
        .clock_out_a(clock_out_a), .clock_out_a_n(clock_out_a_n), .clock_out_b(clock_out_b),
        .clock_out_b_n(clock_out_b_n));
    pll_far_side_model far_i (.clk(clk), .rst_n(rst_n), .slow(slow), .cfg(divider_config), .lock_raw(lock_raw));
    task finish_test;
        if (errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_lock;
        for (int n = 0; n < 300 && lock_out !== 1'b1; n++) @(posedge clk);
    endtask
    task count(input int n);
        logic pa, pb;
        ra = 0;
        rb = 0;
        pa = clock_out_a;
        pb = clock_out_b;
        repeat (n) begin
            @(posedge clk);
            ra += int'(clock_out_a && !pa);
            rb += int'(clock_out_b && !pb);
            pa = clock_out_a;
            pb = clock_out_b;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #(100 * 6000);
        errors++;
        finish_test();
    end
    initial begin
        {rst_n, psel, penable, pwrite, master_reset_n, production_test_in, slow} = 7'h00;
        {parallel_load_select_n, bypass_select_n, reference_valid} = 3'h7;
        output_run_enable_n = 2'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        divider_pins = 15'h1234;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, A_STAT, 32'h0);
        chk("refused", {31'h0, err}, 32'h1);
        master_reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        apb(1'b0, A_ACT, 32'h0);
        chk("startup cfg", rd, 32'h1234);
        wait_lock();
        apb(1'b0, A_STAT, 32'h0);
        chk("status", rd, 32'h7);
        chk("status err", {31'h0, err}, 32'h0);
        apb(1'b1, A_STAT, 32'h0);
        apb(1'b1, A_ACT, 32'h0);
        apb(1'b0, A_STAT, 32'h0);
        chk("status ro", rd, 32'h7);
        apb(1'b0, A_ACT, 32'h0);
        chk("active ro", rd, 32'h1234);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        apb(1'b0, pll_ctrl_pkg::OFS_COMMAND, 32'h0);
        chk("command read", rd, 32'h0);
        apb(1'b1, A_STAGE, 32'h5673);
        apb(1'b0, A_STAGE, 32'h0);
        chk("stage", rd, 32'h5673);
        apb(1'b1, pll_ctrl_pkg::OFS_COMMAND, 32'h1);
        @(negedge clk);
        chk("lock drop", {31'h0, lock_out}, 32'h0);
        apb(1'b0, A_ACT, 32'h0);
        chk("serial load", rd, 32'h5673);
        wait_lock();
        chk("relock", {31'h0, lock_out}, 32'h1);
        output_run_enable_n <= 2'h3;
        repeat (10) @(posedge clk);
        count(32);
        chk("a rises", ra, 16);
        chk("b rises", rb, 8);
        output_run_enable_n <= 2'h2;
        repeat (8) @(posedge clk);
        count(16);
        chk("a stopped", ra, 0);
        chk("b runs", rb, 4);
        chk("a parked", {clock_out_a, clock_out_a_n}, 2'h1);
        output_run_enable_n <= 2'h3;
        slow <= 1'b1;
        reference_valid <= 1'b0;
        apb(1'b1, A_STAGE, 32'h0A03);
        apb(1'b1, pll_ctrl_pkg::OFS_COMMAND, 32'h1);
        repeat (60) @(posedge clk);
        apb(1'b0, A_STAT, 32'h0);
        chk("no ref", rd, 32'h2);
        reference_valid <= 1'b1;
        wait_lock();
        chk("ref back", {31'h0, lock_out}, 32'h1);
        bypass_select_n <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            production_test_in <= i[0];
            repeat (6) @(posedge clk);
            chk("test out", {31'h0, lock_out}, i);
        end
        bypass_select_n <= 1'b1;
        output_run_enable_n <= 2'h0;
        parallel_load_select_n <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            divider_pins <= i[0] ? 15'h4002 : 15'h7FFE;
            repeat (6) @(posedge clk);
            apb(1'b0, A_ACT, 32'h0);
            chk("pins", rd, i[0] ? 32'h4002 : 32'h7FFE);
            apb(1'b0, A_STAGE, 32'h0);
            chk("pins stage", rd, i[0] ? 32'h4002 : 32'h7FFE);
        end
        chk("b parked", {clock_out_b, clock_out_b_n}, 2'h1);
        output_run_enable_n <= 2'h3;
        repeat (20) @(posedge clk);
        master_reset_n <= 1'b0;
        #1;
        chk("mr force", {clock_out_a, clock_out_b, clock_out_a_n, clock_out_b_n}, 4'h3);
        repeat (4) @(posedge clk);
        chk("mr lock", {31'h0, lock_out}, 32'h0);
        finish_test();
    end
endmodule // pll_lock_and_output_stop_tb
